// ===== include/cwd_consts.svh
// constants for the configuration word option decoder
// assumes a 14-bit configuration word, bit 0 being the lowest oscillator select bit
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CWD_DEBUG_BIT 13
`define CWD_LVP_BIT 12
`define CWD_FCM_BIT 11
`define CWD_SWO_BIT 10
`define CWD_BOR_HI 9
`define CWD_BOR_LO 8
`define CWD_DPROT_BIT 7
`define CWD_PPROT_BIT 6
`define CWD_RSTPIN_BIT 5
`define CWD_POWER_UP_TIMER_BIT 4
`define CWD_WDT_BIT 3
`define CWD_OSC_HI 2
`define CWD_OSC_LO 0

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define CWD_WORD_W 14
`define CWD_WORD_ERASED 14'h3fff
`define CWD_BOR_ALWAYS 2'h3
`define CWD_BOR_AWAKE 2'h2
`define CWD_BOR_SOFT 2'h1
`define CWD_BOR_OFF 2'h0

`endif

// ===== include/cwd_pkg.sv
// types shared by the configuration word option decoder
// assumes nothing beyond the constants header
package cwd_pkg;

  // ----------------------------------------------------------------
  // oscillator modes, in field-code order 000 to 111
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CWD_OSC_LOW_POWER_XTAL,
    CWD_OSC_STD_XTAL,
    CWD_OSC_HIGH_SPEED_XTAL,
    CWD_OSC_EXT_CLOCK,
    CWD_OSC_INTERNAL_IO,
    CWD_OSC_INTERNAL_CLOCK_OUTPUT_PIN,
    CWD_OSC_RC_IO,
    CWD_OSC_RC_CLOCK_OUTPUT_PIN
  } cwd_osc_type;

endpackage

// ===== rtl/cwd_osc_decode.sv
// oscillator select field decoder
// assumes a static three-bit code; purely combinational
`timescale 1ns/1ps

module cwd_osc_decode (
  input wire logic [2:0] code_i,
  output cwd_pkg::cwd_osc_type mode_o,
  output logic clock_output_pin_on_o,
  output logic osc2_gpio_o,
  output logic osc1_gpio_o,
  output logic rc_or_internal_o
);

  always_comb begin
    mode_o = cwd_pkg::CWD_OSC_LOW_POWER_XTAL;
    clock_output_pin_on_o = 1'b0;
    osc2_gpio_o = 1'b0;
    osc1_gpio_o = 1'b0;
    rc_or_internal_o = 1'b0;
    case (code_i)
      3'h7: begin
        mode_o = cwd_pkg::CWD_OSC_RC_CLOCK_OUTPUT_PIN;
        clock_output_pin_on_o = 1'b1;
        rc_or_internal_o = 1'b1;
      end
      3'h6: begin
        mode_o = cwd_pkg::CWD_OSC_RC_IO;
        osc2_gpio_o = 1'b1;
        rc_or_internal_o = 1'b1;
      end
      3'h5: begin
        mode_o = cwd_pkg::CWD_OSC_INTERNAL_CLOCK_OUTPUT_PIN;
        clock_output_pin_on_o = 1'b1;
        osc1_gpio_o = 1'b1;
        rc_or_internal_o = 1'b1;
      end
      3'h4: begin
        mode_o = cwd_pkg::CWD_OSC_INTERNAL_IO;
        osc2_gpio_o = 1'b1;
        osc1_gpio_o = 1'b1;
        rc_or_internal_o = 1'b1;
      end
      3'h3: begin
        mode_o = cwd_pkg::CWD_OSC_EXT_CLOCK;
        osc2_gpio_o = 1'b1;
      end
      3'h2: mode_o = cwd_pkg::CWD_OSC_HIGH_SPEED_XTAL;
      3'h1: mode_o = cwd_pkg::CWD_OSC_STD_XTAL;
      default: mode_o = cwd_pkg::CWD_OSC_LOW_POWER_XTAL;
    endcase
  end

endmodule

// ===== rtl/cwd_bor_select.sv
// brown-out enable selection
// assumes sleep and software enable are synchronous levels
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_bor_select (
  input wire logic [1:0] mode_i,
  input wire logic sleep_i,
  input wire logic soft_on_i,
  output logic bor_on_o
);

  always_comb begin
    case (mode_i)
      `CWD_BOR_ALWAYS: bor_on_o = 1'b1;
      `CWD_BOR_AWAKE: bor_on_o = !sleep_i;
      `CWD_BOR_SOFT: bor_on_o = soft_on_i;
      default: bor_on_o = 1'b0;
    endcase
  end

endmodule

// ===== rtl/cwd_config_decode.sv
// configuration word one: holds the word and decodes it into option selects
// assumes the word arrives from non-volatile memory, valid from reset release,
// and that the programmer writes it with a one-cycle strobe; all inputs synchronous
//
// What this block does
// - bit 13 high: debugger off, serial clock/data pins are I/O; low: debugger owns them
// - bit 12 high: program-mode pin active, low-voltage programming; low: pin is I/O
// - bit 11 turns the fail-safe clock monitor on or off
// - bit 10 turns internal/external clock switchover on or off
// - brown-out field: 11 on, 10 on unless asleep, 01 software, 00 off
// - bit 7 low protects data memory; high leaves it unprotected
// - bit 6 low protects program memory; high leaves it unprotected
// - bit 5 high: pin is external reset; low: pin is input, reset held inactive
// - bit 4 low runs the power-up timer; high skips it
// - bit 3 high forces the watchdog on; low leaves it to software
// - oscillator code 111: RC on clock input, clock output driven
// - oscillator code 110: RC on clock input, second pin is I/O
// - oscillator code 101: internal oscillator, clock output, clock input pin I/O
// - oscillator code 100: internal oscillator, both pins I/O
// - brown-out enable never turns on the power-up timer by itself
// - turning data protection off erases the whole data EEPROM
// - turning program protection off erases the whole program memory
// - external reset in internal or RC mode stops the internal oscillator
// - programmed bits read 0, erased bits read 1, erased word is all ones
// - brown-out code 01 follows the software brown-out enable bit
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_config_decode #(
  parameter int WORD_W = `CWD_WORD_W
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [WORD_W-1:0] NV_WORD_I,
  input wire logic PROG_WR_I,
  input wire logic [WORD_W-1:0] PROG_DATA_I,
  input wire logic SLEEP_I,
  input wire logic BROWNOUT_SOFTWARE_ON_I,
  input wire logic WATCHDOG_SOFTWARE_ON_I,
  input wire logic EXTERNAL_RESET_PIN_N_I,
  output logic [WORD_W-1:0] CONFIGURATION_WORD_ONE_O,
  output logic WORD_VALID_O,
  output logic DEBUGGER_ON_O,
  output logic SERIAL_PINS_GPIO_O,
  output logic LOW_VOLTAGE_PROGRAM_ENABLE_O,
  output logic PROGRAM_MODE_PIN_GPIO_O,
  output logic FAILSAFE_CLOCK_MONITOR_ON_O,
  output logic CLOCK_SWITCHOVER_ON_O,
  output logic SUPPLY_DROP_RESET_ON_O,
  output logic DATA_MEMORY_PROTECT_O,
  output logic PROGRAM_MEMORY_PROTECT_O,
  output logic RESET_PIN_IS_RESET_O,
  output logic RESET_PIN_GPIO_O,
  output logic EXTERNAL_RESET_O,
  output logic POWER_UP_TIMER_ON_O,
  output logic WATCHDOG_ON_O,
  output cwd_pkg::cwd_osc_type OSCILLATOR_MODE_O,
  output logic CLOCK_OUTPUT_PIN_ON_O,
  output logic OSC2_PIN_GPIO_O,
  output logic CLOCK_INPUT_PIN_GPIO_O,
  output logic OSCILLATOR_STOP_O,
  output logic ERASE_DATA_MEMORY_O,
  output logic ERASE_PROGRAM_MEMORY_O
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // field positions are fixed, so only the documented width can be served
  if (WORD_W != `CWD_WORD_W) begin : g_bad_width
    $error("configuration word width must be 14");
  end

  // ----------------------------------------------------------------
  // word storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic loaded_reg;
  logic erase_data_reg;
  logic erase_data_next;
  logic erase_prog_reg;
  logic erase_prog_next;
  wire prog_take = loaded_reg && PROG_WR_I;

  // first cycle after release copies the stored word; until then the erased
  // pattern stands, which is the safest set of options
  assign word_next = !loaded_reg ? NV_WORD_I : (prog_take ? PROG_DATA_I : word_reg);

  // protection goes off only on a programmer write that lifts a cleared bit
  assign erase_data_next = prog_take && !word_reg[`CWD_DPROT_BIT] &&
    PROG_DATA_I[`CWD_DPROT_BIT];
  assign erase_prog_next = prog_take && !word_reg[`CWD_PPROT_BIT] &&
    PROG_DATA_I[`CWD_PPROT_BIT];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      word_reg <= `CWD_WORD_ERASED;
      loaded_reg <= 1'b0;
      erase_data_reg <= 1'b0;
      erase_prog_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      loaded_reg <= 1'b1;
      erase_data_reg <= erase_data_next;
      erase_prog_reg <= erase_prog_next;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire debug_off = word_reg[`CWD_DEBUG_BIT];
  wire lvp_on = word_reg[`CWD_LVP_BIT];
  wire fcm_on = word_reg[`CWD_FCM_BIT];
  wire swo_on = word_reg[`CWD_SWO_BIT];
  wire [1:0] bor_field = word_reg[`CWD_BOR_HI:`CWD_BOR_LO];
  wire dprot_n = word_reg[`CWD_DPROT_BIT];
  wire pprot_n = word_reg[`CWD_PPROT_BIT];
  wire rstpin_sel = word_reg[`CWD_RSTPIN_BIT];
  wire power_up_timer_off = word_reg[`CWD_POWER_UP_TIMER_BIT];
  wire wdt_forced = word_reg[`CWD_WDT_BIT];
  wire [2:0] osc_field = word_reg[`CWD_OSC_HI:`CWD_OSC_LO];

  cwd_pkg::cwd_osc_type osc_mode;
  logic clock_output_pin_on;
  logic osc2_gpio;
  logic osc1_gpio;
  logic rc_or_internal;
  logic bor_on;

  cwd_osc_decode u_osc (
    .code_i(osc_field),
    .mode_o(osc_mode),
    .clock_output_pin_on_o(clock_output_pin_on),
    .osc2_gpio_o(osc2_gpio),
    .osc1_gpio_o(osc1_gpio),
    .rc_or_internal_o(rc_or_internal)
  );

  cwd_bor_select u_bor (
    .mode_i(bor_field),
    .sleep_i(SLEEP_I),
    .soft_on_i(BROWNOUT_SOFTWARE_ON_I),
    .bor_on_o(bor_on)
  );

  // when the pin is not a reset input the internal reset is tied inactive
  wire ext_reset = rstpin_sel && !EXTERNAL_RESET_PIN_N_I;
  wire osc_stop = ext_reset && rc_or_internal;
  // power-up timer follows its own bit only, never the brown-out field
  wire power_up_timer_on = !power_up_timer_off;
  wire wdt_on = wdt_forced || WATCHDOG_SOFTWARE_ON_I;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // one cycle behind the word; costs latency but keeps every output glitch free
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      DEBUGGER_ON_O <= 1'b0;
      SERIAL_PINS_GPIO_O <= 1'b1;
      LOW_VOLTAGE_PROGRAM_ENABLE_O <= 1'b1;
      PROGRAM_MODE_PIN_GPIO_O <= 1'b0;
      FAILSAFE_CLOCK_MONITOR_ON_O <= 1'b1;
      CLOCK_SWITCHOVER_ON_O <= 1'b1;
      SUPPLY_DROP_RESET_ON_O <= 1'b1;
      DATA_MEMORY_PROTECT_O <= 1'b0;
      PROGRAM_MEMORY_PROTECT_O <= 1'b0;
      RESET_PIN_IS_RESET_O <= 1'b1;
      RESET_PIN_GPIO_O <= 1'b0;
      EXTERNAL_RESET_O <= 1'b0;
      POWER_UP_TIMER_ON_O <= 1'b0;
      WATCHDOG_ON_O <= 1'b1;
      OSCILLATOR_MODE_O <= cwd_pkg::CWD_OSC_RC_CLOCK_OUTPUT_PIN;
      CLOCK_OUTPUT_PIN_ON_O <= 1'b1;
      OSC2_PIN_GPIO_O <= 1'b0;
      CLOCK_INPUT_PIN_GPIO_O <= 1'b0;
      OSCILLATOR_STOP_O <= 1'b0;
    end else begin
      DEBUGGER_ON_O <= !debug_off;
      SERIAL_PINS_GPIO_O <= debug_off;
      LOW_VOLTAGE_PROGRAM_ENABLE_O <= lvp_on;
      PROGRAM_MODE_PIN_GPIO_O <= !lvp_on;
      FAILSAFE_CLOCK_MONITOR_ON_O <= fcm_on;
      CLOCK_SWITCHOVER_ON_O <= swo_on;
      SUPPLY_DROP_RESET_ON_O <= bor_on;
      DATA_MEMORY_PROTECT_O <= !dprot_n;
      PROGRAM_MEMORY_PROTECT_O <= !pprot_n;
      RESET_PIN_IS_RESET_O <= rstpin_sel;
      RESET_PIN_GPIO_O <= !rstpin_sel;
      EXTERNAL_RESET_O <= ext_reset;
      POWER_UP_TIMER_ON_O <= power_up_timer_on;
      WATCHDOG_ON_O <= wdt_on;
      OSCILLATOR_MODE_O <= osc_mode;
      CLOCK_OUTPUT_PIN_ON_O <= clock_output_pin_on;
      OSC2_PIN_GPIO_O <= osc2_gpio;
      CLOCK_INPUT_PIN_GPIO_O <= osc1_gpio;
      OSCILLATOR_STOP_O <= osc_stop;
    end
  end

  assign CONFIGURATION_WORD_ONE_O = word_reg;
  assign WORD_VALID_O = loaded_reg;
  assign ERASE_DATA_MEMORY_O = erase_data_reg;
  assign ERASE_PROGRAM_MEMORY_O = erase_prog_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  sequence data_unprotect_s;
    PROG_WR_I && WORD_VALID_O && !CONFIGURATION_WORD_ONE_O[`CWD_DPROT_BIT] &&
      PROG_DATA_I[`CWD_DPROT_BIT];
  endsequence

  sequence prog_unprotect_s;
    PROG_WR_I && WORD_VALID_O && !CONFIGURATION_WORD_ONE_O[`CWD_PPROT_BIT] &&
      PROG_DATA_I[`CWD_PPROT_BIT];
  endsequence

  debugger_pins_a: assert property (
    WORD_VALID_O && $stable(CONFIGURATION_WORD_ONE_O) |=>
      DEBUGGER_ON_O == !$past(CONFIGURATION_WORD_ONE_O[`CWD_DEBUG_BIT]) &&
      SERIAL_PINS_GPIO_O != DEBUGGER_ON_O)
    else $error("debugger ownership does not follow bit 13");

  low_voltage_prog_a: assert property (
    WORD_VALID_O |=> LOW_VOLTAGE_PROGRAM_ENABLE_O ==
      $past(CONFIGURATION_WORD_ONE_O[`CWD_LVP_BIT]) &&
      PROGRAM_MODE_PIN_GPIO_O == !LOW_VOLTAGE_PROGRAM_ENABLE_O)
    else $error("program-mode pin does not follow bit 12");

  monitor_switch_a: assert property (
    WORD_VALID_O |=> FAILSAFE_CLOCK_MONITOR_ON_O ==
      $past(CONFIGURATION_WORD_ONE_O[`CWD_FCM_BIT]) && CLOCK_SWITCHOVER_ON_O ==
      $past(CONFIGURATION_WORD_ONE_O[`CWD_SWO_BIT]))
    else $error("clock monitor or switchover does not follow its bit");

  brownout_sleep_a: assert property (
    WORD_VALID_O && CONFIGURATION_WORD_ONE_O[`CWD_BOR_HI:`CWD_BOR_LO] == `CWD_BOR_AWAKE
      |=> SUPPLY_DROP_RESET_ON_O == !$past(SLEEP_I))
    else $error("brown-out code 10 does not drop in sleep");

  brownout_soft_a: assert property (
    WORD_VALID_O && CONFIGURATION_WORD_ONE_O[`CWD_BOR_HI:`CWD_BOR_LO] == `CWD_BOR_SOFT
      |=> SUPPLY_DROP_RESET_ON_O == $past(BROWNOUT_SOFTWARE_ON_I))
    else $error("brown-out code 01 does not follow software enable");

  protect_flags_a: assert property (
    WORD_VALID_O |=> DATA_MEMORY_PROTECT_O == !$past(CONFIGURATION_WORD_ONE_O[7]) &&
      PROGRAM_MEMORY_PROTECT_O == !$past(CONFIGURATION_WORD_ONE_O[6]))
    else $error("protection flags do not follow bits 7 and 6");

  reset_pin_tie_a: assert property (
    WORD_VALID_O && !CONFIGURATION_WORD_ONE_O[`CWD_RSTPIN_BIT] |=>
      !EXTERNAL_RESET_O && RESET_PIN_GPIO_O)
    else $error("reset input not held inactive while pin is digital input");

  timer_independent_a: assert property (
    WORD_VALID_O |=> POWER_UP_TIMER_ON_O == !$past(CONFIGURATION_WORD_ONE_O[`CWD_POWER_UP_TIMER_BIT]))
    else $error("power-up timer not set by its own bit alone");

  watchdog_force_a: assert property (
    WORD_VALID_O && (CONFIGURATION_WORD_ONE_O[`CWD_WDT_BIT] || WATCHDOG_SOFTWARE_ON_I)
      |=> WATCHDOG_ON_O)
    else $error("watchdog not on when forced or enabled by software");

  osc_rc_clock_output_pin_a: assert property (
    WORD_VALID_O && CONFIGURATION_WORD_ONE_O[2:0] == 3'h7 |=>
      OSCILLATOR_MODE_O == cwd_pkg::CWD_OSC_RC_CLOCK_OUTPUT_PIN && CLOCK_OUTPUT_PIN_ON_O)
    else $error("code 111 not decoded as RC with clock output");

  osc_internal_io_a: assert property (
    WORD_VALID_O && CONFIGURATION_WORD_ONE_O[2:0] == 3'h4 |=>
      OSC2_PIN_GPIO_O && CLOCK_INPUT_PIN_GPIO_O && !CLOCK_OUTPUT_PIN_ON_O)
    else $error("code 100 does not release both oscillator pins");

  osc_stop_reset_a: assert property (
    WORD_VALID_O && $stable(CONFIGURATION_WORD_ONE_O) && CONFIGURATION_WORD_ONE_O[2] &&
      CONFIGURATION_WORD_ONE_O[`CWD_RSTPIN_BIT] && !EXTERNAL_RESET_PIN_N_I |=>
      OSCILLATOR_STOP_O && EXTERNAL_RESET_O)
    else $error("oscillator not stopped under external reset");

  erase_data_a: assert property (
    data_unprotect_s |=> ERASE_DATA_MEMORY_O ##1 !ERASE_DATA_MEMORY_O)
    else $error("data erase not one pulse after protection removed");

  erase_prog_a: assert property (
    prog_unprotect_s |=> ERASE_PROGRAM_MEMORY_O ##1 !ERASE_PROGRAM_MEMORY_O)
    else $error("program erase not one pulse after protection removed");

  erased_load_a: assert property (
    !WORD_VALID_O |=> WORD_VALID_O && CONFIGURATION_WORD_ONE_O == $past(NV_WORD_I))
    else $error("stored word not taken on the first cycle after reset");

endmodule

// ===== test/cwd_prog_model.sv
// programmer model: supplies the stored word and writes new words with a strobe held one cycle per word (two cycles for a pair)
// assumes the decoder samples its inputs on the rising edge of clk_i
`timescale 1ns/1ps
`include "cwd_consts.svh"

module cwd_prog_model #(
  parameter logic [13:0] NV_INIT = `CWD_WORD_ERASED
) (
  input wire logic clk_i,
  output logic prog_wr_o,
  output logic [13:0] prog_data_o,
  output logic [13:0] nv_word_o
);
  // ----------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------
  // unprogrammed memory reads as all ones unless told otherwise
  initial begin
    prog_wr_o = 1'b0;
    prog_data_o = 14'h0000;
    nv_word_o = NV_INIT;
  end

  // ----------------------------------------------------------------
  // write tasks
  // ----------------------------------------------------------------
  // data is scrambled once released so a stale value never looks valid
  task automatic write_word(input logic [13:0] w);
    @(posedge clk_i);
    prog_wr_o <= 1'b1;
    prog_data_o <= w;
    @(posedge clk_i);
    prog_wr_o <= 1'b0;
    prog_data_o <= ~w;
  endtask

  task automatic write_pair(input logic [13:0] a, input logic [13:0] b);
    @(posedge clk_i);
    prog_wr_o <= 1'b1;
    prog_data_o <= a;
    @(posedge clk_i);
    prog_data_o <= b;
    @(posedge clk_i);
    prog_wr_o <= 1'b0;
    prog_data_o <= ~b;
  endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the configuration word decoder
// assumes a 100 MHz clock and a model of the decode written with integers
`timescale 1ns/1ps

module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sleep = 1'b0;
  logic bsw = 1'b0;
  logic wsw = 1'b0;
  logic pin_n = 1'b1;
  logic prog_wr;
  logic [13:0] prog_data;
  logic [13:0] nv_word;
  logic [13:0] cfg_word;
  logic valid, dbg, ser, low_voltage_program_enable, program_mode_pin, fcm, swo, bor, dprot, pprot, rpin, rgpio, ext;
  logic power_up_timer, wdt, clko, osc2, osc1, stop, erase_d, erase_p;
  cwd_pkg::cwd_osc_type osc_mode;
  wire logic [20:0] seen_vec = {dbg, ser, low_voltage_program_enable, program_mode_pin, fcm, swo, bor, dprot, pprot, rpin, rgpio,
    ext, power_up_timer, wdt, osc_mode, clko, osc2, osc1, stop};
  string fname [0:20] = '{"stop", "osc1_gpio", "osc2_gpio", "clock_output_pin", "mode0", "mode1",
    "mode2", "wdt", "power_up_timer", "ext_reset", "rst_gpio", "rst_is_reset", "prog_prot",
    "data_prot", "bor", "switchover", "fcm", "pgm_gpio", "lvp", "serial_gpio", "debugger"};
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int cw;

  always #5 mclk = ~mclk;

  cwd_prog_model #(.NV_INIT(14'h1b37)) cwd_prog_model_i (.clk_i(mclk), .prog_wr_o(prog_wr),
    .prog_data_o(prog_data), .nv_word_o(nv_word));

  cwd_config_decode cwd_config_decode_i (.MCLK_I(mclk), .RST_I(rst), .NV_WORD_I(nv_word),
    .PROG_WR_I(prog_wr), .PROG_DATA_I(prog_data), .SLEEP_I(sleep),
    .BROWNOUT_SOFTWARE_ON_I(bsw), .WATCHDOG_SOFTWARE_ON_I(wsw),
    .EXTERNAL_RESET_PIN_N_I(pin_n), .CONFIGURATION_WORD_ONE_O(cfg_word),
    .WORD_VALID_O(valid), .DEBUGGER_ON_O(dbg), .SERIAL_PINS_GPIO_O(ser),
    .LOW_VOLTAGE_PROGRAM_ENABLE_O(low_voltage_program_enable), .PROGRAM_MODE_PIN_GPIO_O(program_mode_pin),
    .FAILSAFE_CLOCK_MONITOR_ON_O(fcm), .CLOCK_SWITCHOVER_ON_O(swo),
    .SUPPLY_DROP_RESET_ON_O(bor), .DATA_MEMORY_PROTECT_O(dprot),
    .PROGRAM_MEMORY_PROTECT_O(pprot), .RESET_PIN_IS_RESET_O(rpin), .RESET_PIN_GPIO_O(rgpio),
    .EXTERNAL_RESET_O(ext), .POWER_UP_TIMER_ON_O(power_up_timer), .WATCHDOG_ON_O(wdt),
    .OSCILLATOR_MODE_O(osc_mode), .CLOCK_OUTPUT_PIN_ON_O(clko), .OSC2_PIN_GPIO_O(osc2),
    .CLOCK_INPUT_PIN_GPIO_O(osc1), .OSCILLATOR_STOP_O(stop), .ERASE_DATA_MEMORY_O(erase_d),
    .ERASE_PROGRAM_MEMORY_O(erase_p));

  // ----------------------------------------------------------------
  // reference model and checking
  // ----------------------------------------------------------------
  function automatic logic [20:0] exp_vec(int w, int slp, int bs, int ws, int pn);
    int bm, md, ex, br;
    bm = (w >> 8) & 3;
    md = w & 7;
    ex = ((w >> 5) & 1) & (pn ^ 1);
    br = (bm == 3) ? 1 : (bm == 2) ? (slp ^ 1) : (bm == 1) ? bs : 0;
    return {~w[13], w[13], w[12], ~w[12], w[11], w[10], br[0], ~w[7], ~w[6], w[5], ~w[5],
      ex[0], ~w[4], w[3] | ws[0], md[2:0], md == 7 || md == 5, md == 6 || md == 4 || md == 3,
      md == 5 || md == 4, ex == 1 && md >= 4};
  endfunction

  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_vec();
    logic [20:0] e;
    e = exp_vec(cw, sleep, bsw, wsw, pin_n);
    for (int i = 0; i < 21; i++) begin
      check(fname[i], 14'(seen_vec[i]), 14'(e[i]));
    end
  endtask

  // one write; erase pulses land with the word, decode a cycle later
  task automatic do_write(input int w);
    cwd_prog_model_i.write_word(14'(w));
    #1;
    check("word", cfg_word, 14'(w));
    check("erase_data", 14'(erase_d), 14'(((cw >> 7) & 1) == 0 && ((w >> 7) & 1) == 1));
    check("erase_prog", 14'(erase_p), 14'(((cw >> 6) & 1) == 0 && ((w >> 6) & 1) == 1));
    cw = w;
    @(posedge mclk);
    #1;
    check("erase_data_end", 14'(erase_d), 14'h0000);
    check("erase_prog_end", 14'(erase_p), 14'h0000);
    check_vec();
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  // the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int w;
    void'($urandom(8018));
    cw = 'h3fff;
    repeat (2) @(posedge mclk);
    #1;
    check("valid_in_reset", 14'(valid), 14'h0000);
    check("word_in_reset", cfg_word, 14'h3fff);
    check_vec();
    // a write while the word is not yet valid must be dropped
    cwd_prog_model_i.write_word(14'h0000);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("valid", 14'(valid), 14'h0001);
    check("word_from_store", cfg_word, 14'h1b37);
    cw = 'h1b37;
    @(posedge mclk);
    #1;
    check_vec();
    for (int i = 0; i < 32; i++) begin
      w = ($urandom & 'h3cf8) | (((i / 8) % 4) << 8) | (i % 8);
      w = (i % 4 == 1) ? (w & 'h3f3f) : (i % 4 == 2) ? (w | 'h00c0) : w;
      @(posedge mclk);
      sleep <= 1'($urandom);
      bsw <= 1'($urandom);
      wsw <= 1'($urandom);
      pin_n <= 1'($urandom);
      do_write(w);
      // live inputs act one cycle after they change
      @(posedge mclk);
      sleep <= ~sleep;
      bsw <= 1'($urandom);
      wsw <= ~wsw;
      pin_n <= ~pin_n;
      @(posedge mclk);
      #1;
      check_vec();
    end
    // back-to-back writes: the second one wins
    w = $urandom & 'h3fff;
    cwd_prog_model_i.write_pair(14'h0000, 14'(w));
    #1;
    check("word_pair", cfg_word, 14'(w));
    cw = w;
    @(posedge mclk);
    #1;
    check_vec();
    print_verdict();
  end
endmodule
